// file: include/uvao_pkg.sv
// Constants, carriers and shared arithmetic for the unary vector ALU lane group
package uvao_pkg;

    localparam int LANES_DEF = 32;

    // Opcodes handled by this block
    localparam logic [7:0] OP_COSINE_SINGLE = 8'h36;
    localparam logic [7:0] OP_BITWISE_INVERT = 8'h37;
    localparam logic [7:0] OP_BIT_REVERSE = 8'h38;
    localparam logic [7:0] OP_LEADING_ZERO_COUNT = 8'h39;
    localparam logic [7:0] OP_LOWEST_SET_BIT_INDEX = 8'h3a;
    localparam logic [7:0] OP_SIGN_RUN_LENGTH = 8'h3b;
    localparam logic [7:0] OP_EXPONENT_EXTRACT_DOUBLE = 8'h3c;
    localparam logic [7:0] OP_SIGNIFICAND_EXTRACT_DOUBLE = 8'h3d;
    localparam logic [7:0] OP_FRACTION_DOUBLE = 8'h3e;
    localparam logic [7:0] OP_EXPONENT_EXTRACT_SINGLE = 8'h3f;
    localparam logic [7:0] OP_SIGNIFICAND_EXTRACT_SINGLE = 8'h40;
    localparam logic [7:0] OP_CLEAR_WAVE_EXCEPTIONS = 8'h41;
    localparam logic [7:0] OP_MOVE_INDEXED_DESTINATION = 8'h42;
    localparam logic [7:0] OP_MOVE_INDEXED_SOURCE = 8'h43;
    localparam logic [7:0] OP_MOVE_INDEXED_BOTH = 8'h44;

    // Floating-point formats
    localparam int F32_BIAS = 127;
    localparam int F64_BIAS = 1023;
    localparam int F32_DENORM_SHIFT = 149;
    localparam int F64_DENORM_SHIFT = 1074;
    localparam int F64_INT_EXP = 1075;
    localparam logic [31:0] QNAN32 = 32'hffc0_0000;
    localparam logic [63:0] QNAN64 = 64'hfff8_0000_0000_0000;
    localparam logic [63:0] F64_BELOW_ONE = 64'h3fef_ffff_ffff_ffff;

    // Cosine argument reduction and polynomial, Q16 coefficients
    localparam logic [7:0] COS_INT_EXP = 8'h96;
    localparam logic [7:0] COS_FRAC_EXP = 8'h76;
    localparam logic signed [35:0] COS_ONE = 36'sh0_0001_0000;
    localparam logic signed [35:0] COS_A1 = 36'sh0_0001_3bd4;
    localparam logic signed [35:0] COS_A2 = 36'sh0_0000_40f0;
    localparam logic signed [35:0] COS_A3 = 36'sh0_0000_0557;
    localparam logic signed [35:0] COS_A4 = 36'sh0_0000_003c;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_READ = 1'b1
    } uvao_state_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] dst;
        logic [7:0] src;
        logic [31:0] index;
        logic [5:0] wave;
        logic neg;
        logic abs;
    } uvao_issue_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic wide;
    } uvao_wb_t;

    function automatic logic [6:0] uvao_msb64(input logic [63:0] v);
        logic [6:0] p;
        p = 7'h00;
        for (int i = 0; i < 64; i++) begin
            if (v[i]) begin
                p = 7'(i);
            end
        end
        return p;
    endfunction : uvao_msb64

    // Exact widening; single denormals become normal doubles
    function automatic logic [63:0] uvao_f32_to_f64(input logic [31:0] x);
        logic [63:0] r;
        logic [6:0] p;
        p = uvao_msb64({41'h0, x[22:0]});
        if (x[30:23] == 8'hff) begin
            r = {x[31], 11'h7ff, x[22:0], 29'h0};
        end else if (x[30:23] != 8'h00) begin
            r = {x[31], 11'(x[30:23]) + 11'(F64_BIAS - F32_BIAS), x[22:0], 29'h0};
        end else if (x[22:0] == 23'h0) begin
            r = {x[31], 63'h0};
        end else begin
            r = {x[31], 11'(p) + 11'(F64_BIAS - F32_DENORM_SHIFT),
                 52'({41'h0, x[22:0]} << (7'd52 - p))};
        end
        return r;
    endfunction : uvao_f32_to_f64

    function automatic logic [31:0] uvao_frexp_exp64(input logic [63:0] d);
        logic [31:0] r;
        logic [6:0] p;
        p = uvao_msb64({12'h0, d[51:0]});
        if (d[62:52] == 11'h7ff || d[62:0] == 63'h0) begin
            r = 32'h0000_0000;
        end else if (d[62:52] != 11'h0) begin
            r = 32'({21'h0, d[62:52]}) - 32'(F64_BIAS) + 32'h0000_0001;
        end else begin
            r = 32'(p) - 32'(F64_DENORM_SHIFT) + 32'h0000_0001;
        end
        return r;
    endfunction : uvao_frexp_exp64

    function automatic logic [63:0] uvao_frexp_mant64(input logic [63:0] d);
        logic [63:0] r;
        logic [6:0] p;
        p = uvao_msb64({12'h0, d[51:0]});
        if (d[62:52] == 11'h7ff || d[62:0] == 63'h0) begin
            r = d;
        end else if (d[62:52] != 11'h0) begin
            r = {d[63], 11'(F64_BIAS - 1), d[51:0]};
        end else begin
            r = {d[63], 11'(F64_BIAS - 1), 52'({12'h0, d[51:0]} << (7'd52 - p))};
        end
        return r;
    endfunction : uvao_frexp_mant64

endpackage : uvao_pkg

// file: core/uvao_cosine_lane.sv
// Single-precision cosine of one lane, argument in turns
`timescale 1ns/1ns
module uvao_cosine_lane (
    // Operand
    input wire logic [31:0] x_i,
    // Result
    output logic [31:0] y_o
);

    function automatic logic signed [35:0] horner(input logic signed [35:0] a,
                                                  input logic signed [35:0] t,
                                                  input logic [17:0] z);
        logic signed [55:0] prod;
        prod = 56'(t) * $signed({38'h0, z});
        return a - 36'(prod >>> 16);
    endfunction : horner

    logic [7:0] ex;
    logic [23:0] man;
    logic [31:0] frac;
    logic [1:0] quad;
    logic [16:0] v;
    logic [33:0] vv;
    logic [17:0] z;
    logic signed [35:0] acc;
    logic [16:0] c;
    logic [6:0] p;

    always_comb begin
        ex = x_i[30:23];
        man = {ex != 8'h00, x_i[22:0]};
        // Sign is ignored because cosine is even; denormals reduce to a zero phase
        if (ex >= uvao_pkg::COS_INT_EXP) begin
            frac = 32'h0000_0000;
        end else if (ex >= uvao_pkg::COS_FRAC_EXP) begin
            frac = 32'({40'h0, man} << (ex - uvao_pkg::COS_FRAC_EXP));
        end else begin
            frac = 32'({40'h0, man} >> (uvao_pkg::COS_FRAC_EXP - ex));
        end
        quad = frac[31:30];
        // Odd quarters mirror the argument so one polynomial serves all four
        v = quad[0] ? 17'h1_0000 - {1'b0, frac[29:14]} : {1'b0, frac[29:14]};
        vv = 34'(v) * 34'(v);
        z = vv[33:16];
        acc = horner(uvao_pkg::COS_A3, uvao_pkg::COS_A4, z);
        acc = horner(uvao_pkg::COS_A2, acc, z);
        acc = horner(uvao_pkg::COS_A1, acc, z);
        acc = horner(uvao_pkg::COS_ONE, acc, z);
        c = acc[35] ? 17'h0_0000 : acc[16:0];
        p = uvao_pkg::uvao_msb64({47'h0, c});
        if (ex == 8'hff) begin
            y_o = uvao_pkg::QNAN32; // [RQ2]
        end else if ((quad[0] && frac[29:0] == 30'h0) || c == 17'h0_0000) begin
            y_o = 32'h0000_0000;
        end else begin
            y_o = {quad[0] ^ quad[1], 8'(uvao_pkg::F32_BIAS - 16) + 8'(p),
                   23'((40'(c) << 23) >> p)}; // [RQ1]
        end
    end

endmodule : uvao_cosine_lane

// file: core/uvao_unary_alu.sv
// Lane group that executes the single-source vector ALU opcodes 54 to 68
`timescale 1ns/1ns

// What this block does
// [RQ1] Opcode 54 returns cosine of operand times two pi, denormals accepted.
// [RQ2] Cosine of infinity gives the quiet NaN; negative zero gives exactly one.
// [RQ3] Opcode 55 inverts all 32 bits, ignoring input and output modifiers.
// [RQ4] Opcode 56 mirrors the 32 bits end to end, no modifiers.
// [RQ5] Opcode 57 counts zeros above the top set bit; all ones if zero.
// [RQ6] Opcode 58 gives index of lowest set bit, or minus one.
// [RQ7] Opcode 59 gives first bit position differing from sign, or minus one.
// [RQ8] Opcode 60 gives double exponent minus 1023 plus one; zero for infinity.
// [RQ9] Opcode 61 gives double significand in half-to-one range; infinity passes.
// [RQ10] Opcode 62 gives double operand minus its floor, denormals accepted.
// [RQ11] Opcode 63 gives single exponent minus 127 plus one; zero for infinity.
// [RQ12] Opcode 64 gives single significand in half-to-one range; infinity passes.
// [RQ13] Opcode 65 clears the issuing wave's exception state, writes no register.
// [RQ14] Opcode 66 writes source to register at destination plus index value.
// [RQ15] Opcode 67 reads register at source plus index, writes destination.
// [RQ16] Opcode 68 offsets both source and destination by the index value.
// [RQ17] Program loads the index register with the wanted offset beforehand.
// [RQ18] Every enabled lane is evaluated; only enabled lanes are written.
module uvao_unary_alu #(
    parameter int LANES = uvao_pkg::LANES_DEF
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Issue from the sequencer
    input wire logic issue_valid_i,
    input wire uvao_pkg::uvao_issue_t issue_i,
    input wire logic [LANES-1:0] lane_enable_i,
    input wire logic [LANES-1:0][63:0] operand_i,
    output logic issue_ready_o,
    // Indexed source read from the register file
    output logic rf_rd_req_o,
    output logic [31:0] rf_rd_addr_o,
    input wire logic rf_rd_ack_i,
    input wire logic [LANES-1:0][31:0] rf_rd_data_i,
    // Write-back to the register file
    output uvao_pkg::uvao_wb_t wb_o,
    output logic [LANES-1:0] wb_lane_mask_o,
    output logic [LANES-1:0][63:0] wb_data_o,
    // Exception state clear
    output logic excp_clear_o,
    output logic [5:0] excp_wave_o
);

    // Operand minus its floor, rounded to nearest even
    function automatic logic [63:0] fract64(input logic [63:0] d);
        logic [10:0] e;
        logic [52:0] m;
        logic [11:0] k;
        logic [127:0] wide;
        logic [127:0] sh;
        logic [63:0] f;
        logic st;
        logic [63:0] r;
        logic [6:0] p;
        logic [63:0] n;
        logic up;
        logic [53:0] q;
        logic [51:0] mf;
        logic [63:0] res;
        e = d[62:52];
        m = {e != 11'h0, d[51:0]};
        k = 12'(uvao_pkg::F64_INT_EXP) - ((e == 11'h0) ? 12'h001 : {1'b0, e});
        wide = {11'h0, m, 64'h0};
        sh = wide >> k;
        f = sh[63:0];
        st = (sh << k) != wide;
        mf = d[51:0] & ((52'h1 << k) - 52'h1);
        r = st ? ~f : (~f + 64'h1);
        p = uvao_pkg::uvao_msb64(d[63] ? r : {12'h0, mf});
        n = r << (7'd63 - p);
        up = n[10] & (n[11] | (|n[9:0]) | st);
        q = {1'b0, n[63:11]} + 54'(up);
        if (e == 11'h7ff) begin
            res = uvao_pkg::QNAN64;
        end else if (e >= 11'(uvao_pkg::F64_INT_EXP)) begin
            res = 64'h0;
        end else if (!d[63]) begin
            if (e < 11'(uvao_pkg::F64_BIAS)) begin
                res = d;
            end else if (mf == 52'h0) begin
                res = 64'h0;
            end else begin
                res = {1'b0, e + 11'(p) - 11'h034, 52'({12'h0, mf} << (7'd52 - p))};
            end
        end else if (f == 64'h0 && !st) begin
            res = 64'h0;
        end else if (q[53] && p == 7'd63) begin
            // Keep the result below one when the complement rounds up
            res = uvao_pkg::F64_BELOW_ONE;
        end else begin
            res = {1'b0, 11'(uvao_pkg::F64_BIAS - 64) + 11'(p) + 11'(q[53]),
                   q[53] ? 52'h0 : q[51:0]};
        end
        return res;
    endfunction : fract64

    function automatic logic [31:0] search_result(input logic [31:0] v);
        logic [6:0] p;
        p = uvao_pkg::uvao_msb64({32'h0, v});
        return (v == 32'h0) ? 32'hffff_ffff : 32'(7'd31 - p);
    endfunction : search_result

    function automatic logic [63:0] lane_op(input logic [7:0] op,
                                            input logic [63:0] s,
                                            input logic [63:0] fd,
                                            input logic [31:0] fs,
                                            input logic [31:0] cosv);
        logic [31:0] w;
        logic [63:0] wd;
        logic [63:0] res;
        w = 32'hffff_ffff;
        for (int i = 31; i >= 0; i--) begin
            if (s[i]) begin
                w = 32'(i);
            end
        end
        wd = uvao_pkg::uvao_frexp_mant64(uvao_pkg::uvao_f32_to_f64(fs));
        case (op)
            uvao_pkg::OP_COSINE_SINGLE: res = {32'h0, cosv}; // [RQ1]
            uvao_pkg::OP_BITWISE_INVERT: res = {32'h0, ~s[31:0]}; // [RQ3]
            uvao_pkg::OP_BIT_REVERSE: res = {32'h0, 32'({<<{s[31:0]}})}; // [RQ4]
            uvao_pkg::OP_LEADING_ZERO_COUNT: res = {32'h0, search_result(s[31:0])}; // [RQ5]
            uvao_pkg::OP_LOWEST_SET_BIT_INDEX: res = {32'h0, w}; // [RQ6]
            uvao_pkg::OP_SIGN_RUN_LENGTH: begin
                // Bit 31 never differs from itself, so it is masked out
                res = {32'h0, search_result({1'b0, s[30:0] ^ {31{s[31]}}})}; // [RQ7]
            end
            uvao_pkg::OP_EXPONENT_EXTRACT_DOUBLE: begin
                res = {32'h0, uvao_pkg::uvao_frexp_exp64(fd)}; // [RQ8]
            end
            uvao_pkg::OP_SIGNIFICAND_EXTRACT_DOUBLE: res = uvao_pkg::uvao_frexp_mant64(fd); // [RQ9]
            uvao_pkg::OP_FRACTION_DOUBLE: res = fract64(fd); // [RQ10]
            uvao_pkg::OP_EXPONENT_EXTRACT_SINGLE: begin
                res = {32'h0, uvao_pkg::uvao_frexp_exp64(uvao_pkg::uvao_f32_to_f64(fs))}; // [RQ11]
            end
            uvao_pkg::OP_SIGNIFICAND_EXTRACT_SINGLE: begin
                if (fs[30:23] == 8'hff || fs[30:0] == 31'h0) begin
                    res = {32'h0, fs}; // [RQ12]
                end else begin
                    res = {32'h0, wd[63], 8'(uvao_pkg::F32_BIAS - 1), wd[51:29]}; // [RQ12]
                end
            end
            uvao_pkg::OP_MOVE_INDEXED_DESTINATION: res = {32'h0, s[31:0]}; // [RQ14]
            default: res = 64'h0;
        endcase
        return res;
    endfunction : lane_op

    function automatic logic is_wide(input logic [7:0] op);
        return op == uvao_pkg::OP_SIGNIFICAND_EXTRACT_DOUBLE || op == uvao_pkg::OP_FRACTION_DOUBLE;
    endfunction : is_wide

    uvao_pkg::uvao_state_t state_r;
    logic [31:0] rd_addr_r;
    logic [31:0] pend_dst_r;
    logic [LANES-1:0] pend_mask_r;
    uvao_pkg::uvao_wb_t wb_r;
    logic [LANES-1:0] mask_r;
    logic [LANES-1:0][63:0] data_r;
    logic clr_r;
    logic [5:0] wave_r;

    logic take;
    logic [7:0] op;
    logic is_read;
    logic is_known;
    logic [31:0] idx_dst;
    logic [31:0] idx_src;
    logic [LANES-1:0][63:0] lane_res;

    assign op = issue_i.opcode;
    assign issue_ready_o = state_r == uvao_pkg::ST_IDLE;
    assign take = issue_valid_i && issue_ready_o;
    assign is_read = op == uvao_pkg::OP_MOVE_INDEXED_SOURCE || op == uvao_pkg::OP_MOVE_INDEXED_BOTH;
    assign is_known = op >= uvao_pkg::OP_COSINE_SINGLE && op <= uvao_pkg::OP_MOVE_INDEXED_BOTH;
    // Full 32-bit index; the register file decides what lies out of range
    assign idx_dst = 32'({24'h0, issue_i.dst}) + issue_i.index; // [RQ14] [RQ16]
    assign idx_src = 32'({24'h0, issue_i.src}) + issue_i.index; // [RQ15] [RQ16]

    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [63:0] fd;
        logic [31:0] fs;
        logic [31:0] cosv;
        // Float operations honour abs then neg; integer operations see the raw operand
        assign fd = {(operand_i[l][63] & ~issue_i.abs) ^ issue_i.neg, operand_i[l][62:0]};
        assign fs = {(operand_i[l][31] & ~issue_i.abs) ^ issue_i.neg, operand_i[l][30:0]};
        uvao_cosine_lane u_cos (
            .x_i(fs),
            .y_o(cosv)
        );
        assign lane_res[l] = lane_op(op, operand_i[l], fd, fs, cosv);
    end

    assign rf_rd_req_o = state_r == uvao_pkg::ST_READ;
    assign rf_rd_addr_o = rd_addr_r;
    assign wb_o = wb_r;
    assign wb_lane_mask_o = mask_r;
    assign wb_data_o = data_r;
    assign excp_clear_o = clr_r;
    assign excp_wave_o = wave_r;

    // Indexed source read sequencing
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            state_r <= uvao_pkg::ST_IDLE;
            rd_addr_r <= 32'h0000_0000;
            pend_dst_r <= 32'h0000_0000;
            pend_mask_r <= '0;
        end else begin
            case (state_r)
                uvao_pkg::ST_IDLE: begin
                    if (take && is_read) begin
                        state_r <= uvao_pkg::ST_READ;
                        rd_addr_r <= idx_src; // [RQ15] [RQ16]
                        pend_dst_r <= (op == uvao_pkg::OP_MOVE_INDEXED_BOTH) ? idx_dst :
                                      32'({24'h0, issue_i.dst}); // [RQ15] [RQ16]
                        pend_mask_r <= lane_enable_i;
                    end
                end
                uvao_pkg::ST_READ: begin
                    if (rf_rd_ack_i) begin
                        state_r <= uvao_pkg::ST_IDLE;
                    end
                end
                default: state_r <= uvao_pkg::ST_IDLE;
            endcase
        end
    end

    // Write-back stage
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            wb_r <= '0;
            mask_r <= '0;
            data_r <= '0;
        end else if (state_r == uvao_pkg::ST_READ && rf_rd_ack_i) begin
            wb_r <= '{valid: 1'b1, addr: pend_dst_r, wide: 1'b0};
            mask_r <= pend_mask_r; // [RQ18]
            for (int l = 0; l < LANES; l++) begin
                data_r[l] <= {32'h0, rf_rd_data_i[l]}; // [RQ15] [RQ16]
            end
        end else if (take && is_known && !is_read && op != uvao_pkg::OP_CLEAR_WAVE_EXCEPTIONS) begin
            wb_r.valid <= 1'b1;
            wb_r.addr <= (op == uvao_pkg::OP_MOVE_INDEXED_DESTINATION) ? idx_dst :
                         32'({24'h0, issue_i.dst}); // [RQ14]
            wb_r.wide <= is_wide(op);
            mask_r <= lane_enable_i; // [RQ18]
            data_r <= lane_res; // [RQ18]
        end else begin
            wb_r.valid <= 1'b0;
        end
    end

    // Exception clear is a pulse tagged with the issuing wave only
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            clr_r <= 1'b0;
            wave_r <= 6'h00;
        end else begin
            clr_r <= take && op == uvao_pkg::OP_CLEAR_WAVE_EXCEPTIONS; // [RQ13]
            if (take && op == uvao_pkg::OP_CLEAR_WAVE_EXCEPTIONS) begin
                wave_r <= issue_i.wave; // [RQ13]
            end
        end
    end

endmodule : uvao_unary_alu

// file: testbench/uvao_sva.sv
// Port-level assertions for the unary vector ALU lane group
`timescale 1ns/1ns
module uvao_sva #(
    parameter int LANES = 2
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Issue
    input wire logic issue_valid_i,
    input wire uvao_pkg::uvao_issue_t issue_i,
    input wire logic [LANES-1:0] lane_enable_i,
    input wire logic [LANES-1:0][63:0] operand_i,
    input wire logic issue_ready_o,
    // Indexed read
    input wire logic rf_rd_req_o,
    input wire logic [31:0] rf_rd_addr_o,
    input wire logic rf_rd_ack_i,
    input wire logic [LANES-1:0][31:0] rf_rd_data_i,
    // Write-back and exception clear
    input wire uvao_pkg::uvao_wb_t wb_o,
    input wire logic [LANES-1:0] wb_lane_mask_o,
    input wire logic [LANES-1:0][63:0] wb_data_o,
    input wire logic excp_clear_o,
    input wire logic [5:0] excp_wave_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    logic taken;
    logic [7:0] op;
    assign taken = issue_valid_i && issue_ready_o;
    assign op = issue_i.opcode;
    sequence s_rd_taken;
        taken && (op == uvao_pkg::OP_MOVE_INDEXED_SOURCE || op == uvao_pkg::OP_MOVE_INDEXED_BOTH);
    endsequence
    sequence s_rd_wait;
        rf_rd_req_o && !rf_rd_ack_i;
    endsequence
    sequence s_rd_done;
        rf_rd_req_o && rf_rd_ack_i;
    endsequence
    AST_DIRECT_WB: assert property (
        taken && op >= uvao_pkg::OP_COSINE_SINGLE && op <= uvao_pkg::OP_SIGNIFICAND_EXTRACT_SINGLE
        |=> wb_o.valid && wb_lane_mask_o == $past(lane_enable_i)) else $error("direct result missing");
    AST_INVERT: assert property (
        taken && op == uvao_pkg::OP_BITWISE_INVERT && lane_enable_i[0]
        |=> wb_data_o[0] == {32'h0000_0000, ~$past(operand_i[0][31:0])}) else $error("invert wrong");
    AST_CLEAR: assert property (
        taken && op == uvao_pkg::OP_CLEAR_WAVE_EXCEPTIONS
        |=> excp_clear_o && !wb_o.valid && excp_wave_o == $past(issue_i.wave)) else $error("clear wrong");
    AST_RD_ISSUE: assert property (
        s_rd_taken |=> rf_rd_req_o && !issue_ready_o
        && rf_rd_addr_o == 32'($past(issue_i.src)) + $past(issue_i.index)) else $error("read addr wrong");
    AST_RD_HOLD: assert property (
        s_rd_wait |=> rf_rd_req_o && $stable(rf_rd_addr_o) && !wb_o.valid) else $error("read not held");
    AST_RD_WB: assert property (
        s_rd_done |=> wb_o.valid && !rf_rd_req_o && (!wb_lane_mask_o[LANES-1]
        || wb_data_o[LANES-1] == {32'h0000_0000, $past(rf_rd_data_i[LANES-1])})) else $error("read wb wrong");
    AST_MOVD: assert property (
        taken && op == uvao_pkg::OP_MOVE_INDEXED_DESTINATION
        |=> wb_o.valid && wb_o.addr == 32'($past(issue_i.dst)) + $past(issue_i.index)) else $error("movd wrong");
    AST_WIDE: assert property (
        taken && (op == uvao_pkg::OP_SIGNIFICAND_EXTRACT_DOUBLE || op == uvao_pkg::OP_FRACTION_DOUBLE)
        |=> wb_o.wide) else $error("wide flag missing");
endmodule : uvao_sva

bind uvao_unary_alu uvao_sva #(.LANES(LANES)) u_sva (.mclk_i, .rst_b_i, .issue_valid_i, .issue_i,
    .lane_enable_i, .operand_i, .issue_ready_o, .rf_rd_req_o, .rf_rd_addr_o, .rf_rd_ack_i,
    .rf_rd_data_i, .wb_o, .wb_lane_mask_o, .wb_data_o, .excp_clear_o, .excp_wave_o);

// file: testbench/uvao_rf_model.sv
// Register-file read responder at the far side of the lane group
`timescale 1ns/1ns
module uvao_rf_model #(
    parameter int LANES = 2
) (
    // Clock and pacing
    input wire logic mclk_i,
    input wire logic [3:0] delay_i,
    // Read request
    input wire logic rf_rd_req_i,
    input wire logic [31:0] rf_rd_addr_i,
    // Read answer
    output logic rf_rd_ack_o,
    output logic [LANES-1:0][31:0] rf_rd_data_o
);
    logic [3:0] wait_r = 4'h0;
    always @(posedge mclk_i) begin
        if (!rf_rd_req_i || rf_rd_ack_o) begin
            rf_rd_ack_o <= 1'b0;
            wait_r <= 4'h0;
        end else if (wait_r == delay_i) begin
            rf_rd_ack_o <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
    // Idle data is inverted so a stale sample cannot pass for a real read
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            rf_rd_data_o[l] = {rf_rd_addr_i[27:0], 4'(l)} ^ {32{!rf_rd_ack_o}};
        end
    end
endmodule : uvao_rf_model

// file: testbench/unary_vector_alu_ops_tb.sv
// Self-checking bench for the unary vector ALU lane group
`timescale 1ns/1ns
module unary_vector_alu_ops_tb;
    localparam logic [135:0] TBL [28] = '{
        {8'h00, 64'hff80_0000, 64'hffc0_0000}, {8'h00, 64'h7f80_0000, 64'hffc0_0000},
        {8'h00, 64'h8000_0000, 64'h3f80_0000}, {8'h00, 64'h3e80_0000, 64'h0000_0000},
        {8'h00, 64'hff7f_ffff, 64'h3f80_0000}, {8'h01, 64'h1234_5678, 64'hedcb_a987},
        {8'h02, 64'h1234_5678, 64'h1e6a_2c48}, {8'h03, 64'h0000_0000, 64'hffff_ffff},
        {8'h03, 64'h1000_00ff, 64'h0000_0003}, {8'h03, 64'h0000_0001, 64'h0000_001f},
        {8'h04, 64'h0000_0000, 64'hffff_ffff}, {8'h04, 64'hff00_0000, 64'h0000_0018},
        {8'h04, 64'h8000_0000, 64'h0000_001f}, {8'h05, 64'h0000_0000, 64'hffff_ffff},
        {8'h05, 64'h8000_0000, 64'h0000_0001}, {8'h05, 64'h0fff_ffff, 64'h0000_0004},
        {8'h05, 64'hffff_fffe, 64'h0000_001f}, {8'h05, 64'hffff_ffff, 64'hffff_ffff},
        {8'h06, 64'h3ff0_0000_0000_0000, 64'h0001}, {8'h06, 64'h7ff0_0000_0000_0000, 64'h0000},
        {8'h07, 64'hc008_0000_0000_0000, 64'hbfe8_0000_0000_0000},
        {8'h07, 64'hfff0_0000_0000_0000, 64'hfff0_0000_0000_0000},
        {8'h08, 64'hbff4_0000_0000_0000, 64'h3fe8_0000_0000_0000},
        {8'h08, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001},
        {8'h09, 64'h3e80_0000, 64'hffff_ffff}, {8'h09, 64'h7f80_0000, 64'h0000_0000},
        {8'h0a, 64'hc100_0000, 64'hbf00_0000}, {8'h0a, 64'hff80_0000, 64'hff80_0000}};
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic issue_valid_i = 1'b0;
    uvao_pkg::uvao_issue_t issue_i = '0;
    logic [1:0] lane_enable_i = 2'h3;
    logic [1:0][63:0] operand_i = '0;
    logic issue_ready_o, rf_rd_req_o, rf_rd_ack_i, excp_clear_o;
    logic [31:0] rf_rd_addr_o;
    logic [1:0][31:0] rf_rd_data_i;
    uvao_pkg::uvao_wb_t wb_o;
    logic [1:0] wb_lane_mask_o;
    logic [1:0][63:0] wb_data_o;
    logic [5:0] excp_wave_o;
    logic [3:0] delay = 4'h0;
    int err_total = 0, n_tests = 0;
    always #2 mclk_i = ~mclk_i;
    uvao_unary_alu #(.LANES(2)) uut (.mclk_i, .rst_b_i, .issue_valid_i, .issue_i, .lane_enable_i,
        .operand_i, .issue_ready_o, .rf_rd_req_o, .rf_rd_addr_o, .rf_rd_ack_i, .rf_rd_data_i,
        .wb_o, .wb_lane_mask_o, .wb_data_o, .excp_clear_o, .excp_wave_o);
    uvao_rf_model #(.LANES(2)) rf (.mclk_i, .delay_i(delay), .rf_rd_req_i(rf_rd_req_o),
        .rf_rd_addr_i(rf_rd_addr_o), .rf_rd_ack_o(rf_rd_ack_i), .rf_rd_data_o(rf_rd_data_i));
    task automatic test_done();
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask : step
    task automatic drive(input logic [7:0] op, input logic [7:0] d, input logic [31:0] ix,
                         input logic [5:0] w, input logic [1:0] m, input logic [63:0] a);
        issue_valid_i = 1'b1;
        issue_i = '{op, d, 8'h07, ix, w, m[1], m[0]};
        operand_i = {a, a};
    endtask : drive
    // Back-to-back issues, alternating lane masks
    task automatic t_table();
        logic [7:0] k;
        for (int i = 0; i < 28; i++) begin
            k = TBL[i][135:128];
            lane_enable_i = i[0] ? 2'h1 : 2'h3;
            drive(uvao_pkg::OP_COSINE_SINGLE + k, 8'h00, 32'h0, 6'h00, (k == 1 || k == 2) ? 2'h3 : 2'h0,
                  TBL[i][127:64]);
            step();
            chk(wb_o.valid, 1'b1);
            chk(wb_lane_mask_o, lane_enable_i);
            chk(wb_data_o[0], TBL[i][63:0]);
            if (!i[0]) chk(wb_data_o[1], TBL[i][63:0]);
            chk(wb_o.wide, k == 7 || k == 8);
        end
    endtask : t_table
    task automatic t_clear();
        drive(uvao_pkg::OP_CLEAR_WAVE_EXCEPTIONS, 8'h00, 32'h0, 6'h2a, 2'h0, 64'h0);
        step();
        issue_valid_i = 1'b0;
        chk(excp_clear_o, 1'b1);
        chk(excp_wave_o, 6'h2a);
        chk(wb_o.valid, 1'b0);
        step();
        chk(excp_clear_o, 1'b0);
        chk(excp_wave_o, 6'h2a);
    endtask : t_clear
    task automatic t_movd(input logic [7:0] d, input logic [31:0] ix, input logic [31:0] ea);
        drive(uvao_pkg::OP_MOVE_INDEXED_DESTINATION, d, ix, 6'h01, 2'h0, 64'h1111_2222_dead_beef);
        step();
        issue_valid_i = 1'b0;
        chk(wb_o.valid, 1'b1);
        chk(wb_o.addr, ea);
        chk(wb_data_o[0], 64'hdead_beef);
        step();
        chk(wb_o.valid, 1'b0);
    endtask : t_movd
    // Indexed read with a refused issue held up while the read is pending
    task automatic t_rel(input logic [7:0] op, input logic [3:0] dly, input logic [31:0] ea);
        int n;
        n = 0;
        delay = dly;
        lane_enable_i = 2'h2;
        drive(op, 8'h05, 32'h0000_000a, 6'h01, 2'h0, 64'h0);
        step();
        issue_i.opcode = uvao_pkg::OP_CLEAR_WAVE_EXCEPTIONS;
        chk(rf_rd_req_o, 1'b1);
        chk(rf_rd_addr_o, 32'h0000_0011);
        while (rf_rd_ack_i !== 1'b1 && n < 20) begin
            chk(issue_ready_o, 1'b0);
            step();
            chk(excp_clear_o, 1'b0);
            n++;
        end
        chk(64'(n), 64'(dly) + 64'h1);
        step();
        chk(wb_o.valid, 1'b1);
        chk(wb_o.addr, ea);
        chk(wb_lane_mask_o, 2'h2);
        chk(wb_data_o[1], 64'h0000_0111);
        chk(issue_ready_o, 1'b1);
        step();
        chk(excp_clear_o, 1'b1);
    endtask : t_rel
    initial begin
        repeat (6) @(posedge mclk_i);
        #1;
        rst_b_i = 1'b1;
        t_table();
        t_clear();
        t_movd(8'h05, 32'h0000_000a, 32'h0000_000f);
        t_movd(8'h20, 32'hffff_fff0, 32'h0000_0010);
        t_rel(uvao_pkg::OP_MOVE_INDEXED_SOURCE, 4'h0, 32'h0000_0005);
        t_rel(uvao_pkg::OP_MOVE_INDEXED_BOTH, 4'h3, 32'h0000_000f);
        test_done();
    end
    initial begin
        #4000;
        err_total++;
        test_done();
    end
endmodule : unary_vector_alu_ops_tb
